// file: rtl/epmg_pkg.sv
// Package with constants for the emulator pod mode gating block
package epmg_pkg;
  // Processor memory map constants
  localparam logic [15:0] EEPROM_BASE      = 16'hBE00;
  localparam logic [15:0] EEPROM_LAST      = 16'hBFFF;
  localparam logic        WATCHDOG_ENABLE  = 1'h0;
  // Bank protection defaults and width
  localparam int          BANK_PROTECT_REG_W          = 8;
  localparam logic [7:0]  BANK_PROTECT_REG_RESET      = 8'h00;
  // Trace flag reset levels
  localparam logic        FLAG_RESET       = 1'h1;
  // Oneshot flag progress states
  typedef enum logic [1:0] {EPMG_OS_HIGH, EPMG_OS_LOW, EPMG_OS_DONE} epmg_os_t;
endpackage : epmg_pkg

// file: rtl/epmg_top.sv
// Mode dependent gating, status flags and indicators of the emulator pod
//
// Summary of operation
// - Non-maskable interrupt input held high during monitor mode.
// - Gated bus clock held low in monitor mode or emulator-mapped access.
// - Gated bus clock may end emulation with a short final pulse.
// - Ungated selection passes processor bus clock straight to target.
// - Gated read/write held high in monitor mode or emulator-mapped access.
// - Ungated read/write connects target line directly to processor line.
// - Mode status output high in monitor mode, low in emulation.
// - Trace flag low on condition A, high on B; B dominates.
// - Oneshot flag follows trace flag until one high-low-high cycle, then stays high.
// - Monitor indicator off when emulation starts, on after break.
// - Emulation indicator is exact inverse of monitor indicator.
// - Reset indicator lit while processor reset is asserted.
// - Manual reset control resets processor as well as target reset.
// - Without mode pin link, target isolated from the fetch strobe.
// - External qualifiers feed trace; first also feeds breakpoint logic.
// - Every emulator reset reloads bank protection with override value.
// - Processor keeps EEPROM at BE00 to BFFF and watchdog disabled.
// - Chip-select logic stays active when emulation breaks.
`timescale 1ns/100ps
module epmg_top #(
  parameter int BANK_PROTECT_REG_WIDTH = epmg_pkg::BANK_PROTECT_REG_W
) (
  // Clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  // Mode control from the emulator
  input  wire logic                   MONITOR_MODE,
  input  wire logic                   EMU_MAPPED,
  // Option selects
  input  wire logic                   GATED_BUS_CLOCK_SELECT,
  input  wire logic                   GATED_RW_SELECT,
  input  wire logic                   MODE_PIN_LINK,
  // Processor side signals
  input  wire logic                   CPU_BUS_CLOCK,
  input  wire logic                   CPU_RW,
  input  wire logic                   INSTR_FETCH_STROBE_N,
  input  wire logic                   USER_IRQ_N,
  input  wire logic                   TARGET_RESET_N,
  input  wire logic                   MANUAL_RESET_N,
  input  wire logic                   EMU_RESET,
  input  wire logic [BANK_PROTECT_REG_WIDTH-1:0] BANK_PROTECT_REG_OVERRIDE,
  // Trace conditions and qualifiers
  input  wire logic                   TRACE_COND_A,
  input  wire logic                   TRACE_COND_B,
  input  wire logic                   EXT_QUALIFIER_0,
  input  wire logic                   EXT_QUALIFIER_1,
  // Target side outputs
  output logic                        TARGET_BUS_CLOCK,
  output logic                        TARGET_RW,
  output logic                        MODE_PIN_A,
  output logic                        MODE_PIN_A_OE,
  output logic                        NONMASKABLE_IRQ_INPUT,
  output logic                        CPU_RESET_N,
  // Processor configuration outputs
  output logic [BANK_PROTECT_REG_WIDTH-1:0]      BANK_PROTECT_REG,
  output logic                        BANK_PROTECT_LOAD,
  output logic [15:0]                 EEPROM_BASE_ADDR,
  output logic                        WATCHDOG_ENABLE,
  output logic                        CHIP_SELECT_ENABLE,
  // Status and trace outputs
  output logic                        MODE_STATUS_OUT,
  output logic                        TRACE_AB_FLAG,
  output logic                        TRACE_AB_ONESHOT_FLAG,
  output logic [1:0]                  TRACE_QUALIFIERS,
  output logic                        BREAK_QUALIFIER,
  // Indicators
  output logic                        MONITOR_INDICATOR,
  output logic                        EMULATION_INDICATOR,
  output logic                        RESET_INDICATOR
);

  initial begin
    if (BANK_PROTECT_REG_WIDTH < 1 || BANK_PROTECT_REG_WIDTH > 16) begin
      $error("BANK_PROTECT_REG_WIDTH out of range");
    end
  end

  // Synchronisers for pin inputs read by clocked logic
  logic [1:0] sync_mode;
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] sync_q0;
  logic [1:0] sync_q1;
  logic [1:0] sync_rst;
  logic [1:0] sync_erst;

  always_ff @(posedge CLK) begin
    sync_mode <= {sync_mode[0], MONITOR_MODE};
    sync_a    <= {sync_a[0], TRACE_COND_A};
    sync_b    <= {sync_b[0], TRACE_COND_B};
    sync_q0   <= {sync_q0[0], EXT_QUALIFIER_0};
    sync_q1   <= {sync_q1[0], EXT_QUALIFIER_1};
    sync_rst  <= {sync_rst[0], CPU_RESET_N};
    sync_erst <= {sync_erst[0], EMU_RESET};
  end

  // Common mode flag, registered once for every consumer
  logic mode_flag;
  logic next_mode_flag;
  // Trace flag state
  logic flag;
  logic next_flag;
  logic oneshot;
  logic next_oneshot;
  epmg_pkg::epmg_os_t os_state;
  epmg_pkg::epmg_os_t next_os_state;
  // Bank protection reload state
  logic [BANK_PROTECT_REG_WIDTH-1:0] bank_protect_reg;
  logic [BANK_PROTECT_REG_WIDTH-1:0] next_bank_protect_reg;
  logic                   bank_protect_reg_load;
  logic                   next_bank_protect_reg_load;
  logic                   erst_prev;
  logic                   next_erst_prev;
  // Qualifier state
  logic [1:0]             qual;
  logic [1:0]             next_qual;
  logic                   rst_ind;
  logic                   next_rst_ind;

  // Decides whether the target side must see a closed gate this cycle
  function automatic logic gate_closed(input logic monitor, input logic mapped);
    return monitor | mapped;
  endfunction : gate_closed

  // Next mode flag; the single copy that every gate and indicator reads
  always_comb begin
    next_mode_flag = sync_mode[1];
  end

  // Mode flag register; monitor after reset keeps the target side quiet
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mode_flag <= 1'h1;
    end else begin
      mode_flag <= next_mode_flag;
    end
  end

  // Next qualifier pair and reset indicator level
  always_comb begin
    next_qual    = {sync_q1[1], sync_q0[1]};
    next_rst_ind = ~sync_rst[1];
  end

  // Qualifier and reset indicator registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      qual    <= 2'h0;
      rst_ind <= 1'h0;
    end else begin
      qual    <= next_qual;
      rst_ind <= next_rst_ind;
    end
  end

  // Next bank protection value; only the rising edge of the emulator
  // reset reloads, so a reset held high gives exactly one load pulse
  always_comb begin
    next_erst_prev  = sync_erst[1];
    next_bank_protect_reg      = bank_protect_reg;
    next_bank_protect_reg_load = 1'h0;
    if (sync_erst[1] && !erst_prev) begin
      next_bank_protect_reg      = BANK_PROTECT_REG_OVERRIDE;
      next_bank_protect_reg_load = 1'h1;
    end
  end

  // Bank protection registers; a pod reset clears the value
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bank_protect_reg      <= BANK_PROTECT_REG_WIDTH'(epmg_pkg::BANK_PROTECT_REG_RESET);
      bank_protect_reg_load <= 1'h0;
      erst_prev  <= 1'h0;
    end else begin
      bank_protect_reg      <= next_bank_protect_reg;
      bank_protect_reg_load <= next_bank_protect_reg_load;
      erst_prev  <= next_erst_prev;
    end
  end

  // Next trace flag and oneshot progress; B dominates A
  always_comb begin
    if (sync_b[1]) begin
      next_flag = 1'h1;
    end else if (sync_a[1]) begin
      next_flag = 1'h0;
    end else begin
      next_flag = flag;
    end
    next_os_state = os_state;
    case (os_state)
      epmg_pkg::EPMG_OS_HIGH: begin
        if (!next_flag) begin
          next_os_state = epmg_pkg::EPMG_OS_LOW;
        end
      end
      epmg_pkg::EPMG_OS_LOW: begin
        if (next_flag) begin
          next_os_state = epmg_pkg::EPMG_OS_DONE;
        end
      end
      epmg_pkg::EPMG_OS_DONE: begin
        next_os_state = epmg_pkg::EPMG_OS_DONE;
      end
      default: begin
        next_os_state = epmg_pkg::EPMG_OS_HIGH;
      end
    endcase
    // Follows the flag until the full cycle has been seen
    next_oneshot = (next_os_state == epmg_pkg::EPMG_OS_DONE) ? 1'h1 : next_flag;
  end

  // Trace flag registers; both flags rest high after a pod reset,
  // so the oneshot needs a full high-low-high before it latches
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      flag     <= epmg_pkg::FLAG_RESET;
      oneshot  <= epmg_pkg::FLAG_RESET;
      os_state <= epmg_pkg::EPMG_OS_HIGH;
    end else begin
      flag     <= next_flag;
      oneshot  <= next_oneshot;
      os_state <= next_os_state;
    end
  end

  // Gates on the processor pins; combinational paths, the clock included.
  // Gating closes as soon as the mode flag reaches monitor, which may cut
  // the last bus clock pulse short at a break.
  always_comb begin
    if (GATED_BUS_CLOCK_SELECT) begin
      TARGET_BUS_CLOCK = CPU_BUS_CLOCK & ~gate_closed(mode_flag, EMU_MAPPED);
    end else begin
      TARGET_BUS_CLOCK = CPU_BUS_CLOCK;
    end
    if (GATED_RW_SELECT) begin
      TARGET_RW = CPU_RW | gate_closed(mode_flag, EMU_MAPPED);
    end else begin
      TARGET_RW = CPU_RW;
    end
  end

  // Fetch strobe passes to the target only with the link fitted
  assign MODE_PIN_A            = INSTR_FETCH_STROBE_N;
  assign MODE_PIN_A_OE         = MODE_PIN_LINK;
  // Interrupt held inactive high in monitor mode
  assign NONMASKABLE_IRQ_INPUT = USER_IRQ_N | mode_flag;
  // Either reset source resets the processor
  assign CPU_RESET_N           = TARGET_RESET_N & MANUAL_RESET_N;

  // Processor configuration; EEPROM base, watchdog and chip select held fixed
  assign EEPROM_BASE_ADDR      = epmg_pkg::EEPROM_BASE;
  assign WATCHDOG_ENABLE       = epmg_pkg::WATCHDOG_ENABLE;
  assign CHIP_SELECT_ENABLE    = 1'h1;
  assign BANK_PROTECT_REG      = bank_protect_reg;
  assign BANK_PROTECT_LOAD     = bank_protect_reg_load;

  // Status, trace and indicator outputs
  assign MODE_STATUS_OUT       = mode_flag;
  assign TRACE_AB_FLAG         = flag;
  assign TRACE_AB_ONESHOT_FLAG = oneshot;
  assign TRACE_QUALIFIERS      = qual;
  assign BREAK_QUALIFIER       = qual[0];
  assign MONITOR_INDICATOR     = mode_flag;
  assign EMULATION_INDICATOR   = ~mode_flag;
  assign RESET_INDICATOR       = rst_ind;

endmodule : epmg_top

// file: verification/epmg_target_model.sv
// Target board model driving the interrupt request and reset lines
`timescale 1ns/100ps
module epmg_target_model (
  input wire logic       clk,
  input wire logic [1:0] ctl,
  input wire logic       mode_pin_a,
  output logic           user_irq_n = 1'h1,
  output logic           target_reset_n = 1'h1
);
  // Lines change just after an edge; the fetch strobe pin is only listened to, never driven
  always @(posedge clk) {user_irq_n, target_reset_n} <= ctl;
endmodule : epmg_target_model

// file: verification/epmg_top_bench.sv
// Self-checking bench for the pod mode gating block
`timescale 1ns/100ps
module epmg_top_bench;
  logic CLK = 1'h0, RST_N = 1'h0, MONITOR_MODE = 1'h1, EMU_MAPPED = 1'h0, GATED_BUS_CLOCK_SELECT = 1'h0;
  logic GATED_RW_SELECT = 1'h0, MODE_PIN_LINK = 1'h0, CPU_BUS_CLOCK = 1'h0, CPU_RW = 1'h1, MANUAL_RESET_N = 1'h1;
  logic INSTR_FETCH_STROBE_N = 1'h1, EMU_RESET = 1'h0, TRACE_COND_A = 1'h0, TRACE_COND_B = 1'h0;
  logic EXT_QUALIFIER_0 = 1'h0, EXT_QUALIFIER_1 = 1'h0, USER_IRQ_N, TARGET_RESET_N;
  logic [7:0] BANK_PROTECT_REG_OVERRIDE = 8'h00, BANK_PROTECT_REG, seed = 8'h14, r, bp = 8'h00;
  logic [1:0] ctl = 2'h3, TRACE_QUALIFIERS;
  logic [15:0] EEPROM_BASE_ADDR;
  logic TARGET_BUS_CLOCK, TARGET_RW, MODE_PIN_A, MODE_PIN_A_OE, NONMASKABLE_IRQ_INPUT, CPU_RESET_N;
  logic BANK_PROTECT_LOAD, WATCHDOG_ENABLE, CHIP_SELECT_ENABLE, MODE_STATUS_OUT, TRACE_AB_FLAG;
  logic TRACE_AB_ONESHOT_FLAG, BREAK_QUALIFIER, MONITOR_INDICATOR, EMULATION_INDICATOR, RESET_INDICATOR;
  logic fl = 1'h1, os = 1'h1, er_d = 1'h0, m, em, rs;
  logic [40:0] obs, e, exp_q[$];
  int ph = 0, err_count = 0, checks = 0;
  // Design and target board
  epmg_top u_epmg_top (.*);
  epmg_target_model u_epmg_target_model (.clk(CLK), .ctl(ctl), .mode_pin_a(MODE_PIN_A),
    .user_irq_n(USER_IRQ_N), .target_reset_n(TARGET_RESET_N));
  always #20 CLK = ~CLK;
  assign obs = {TARGET_BUS_CLOCK, TARGET_RW, NONMASKABLE_IRQ_INPUT, MODE_STATUS_OUT, MONITOR_INDICATOR,
    EMULATION_INDICATOR, TRACE_AB_FLAG, TRACE_AB_ONESHOT_FLAG, MODE_PIN_A_OE, MODE_PIN_A, CPU_RESET_N, RESET_INDICATOR,
    TRACE_QUALIFIERS, BREAK_QUALIFIER, BANK_PROTECT_REG, WATCHDOG_ENABLE, CHIP_SELECT_ENABLE, EEPROM_BASE_ADDR};
  // Pseudo random source with maximal length taps
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Prints the counts and the verdict, then ends the run
  task automatic final_report;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Takes the oldest note whenever a settled result is due
  always @(negedge CLK) begin
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      checks++;
      if (obs !== e) begin
        err_count++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, obs);
      end
    end
  end
  // Random traffic; each setting is held until every output has settled
  initial begin
    repeat (4) @(posedge CLK);
    RST_N <= 1'h1;
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      r = seed;
      seed = lfsr(seed);
      @(posedge CLK);
      {MONITOR_MODE, EMU_MAPPED, GATED_BUS_CLOCK_SELECT, GATED_RW_SELECT} <= r[7:4];
      {MODE_PIN_LINK, CPU_BUS_CLOCK, CPU_RW, MANUAL_RESET_N} <= r[3:0];
      {ctl, TRACE_COND_A, TRACE_COND_B, EMU_RESET, EXT_QUALIFIER_0, EXT_QUALIFIER_1, INSTR_FETCH_STROBE_N} <= seed;
      BANK_PROTECT_REG_OVERRIDE <= (i % 8 == 0) ? 8'h00 : r ^ seed;
      repeat (5) @(posedge CLK);
      // B dominates A; the oneshot latches high after high-low-high
      if (TRACE_COND_B) fl = 1'h1;
      else if (TRACE_COND_A) fl = 1'h0;
      if (ph == 0 && !fl) ph = 1;
      else if (ph == 1 && fl) ph = 2;
      os = (ph == 2) | fl;
      if (EMU_RESET && !er_d) bp = BANK_PROTECT_REG_OVERRIDE;
      er_d = EMU_RESET;
      m = MONITOR_MODE;
      em = EMU_MAPPED;
      rs = ctl[0] & MANUAL_RESET_N;
      exp_q.push_back({GATED_BUS_CLOCK_SELECT ? CPU_BUS_CLOCK & ~m & ~em : CPU_BUS_CLOCK,
        GATED_RW_SELECT ? CPU_RW | m | em : CPU_RW, ctl[1] | m, m, m, ~m, fl, os, MODE_PIN_LINK,
        INSTR_FETCH_STROBE_N, rs, ~rs,
        EXT_QUALIFIER_1, EXT_QUALIFIER_0, EXT_QUALIFIER_0, bp, epmg_pkg::WATCHDOG_ENABLE, 1'h1,
        epmg_pkg::EEPROM_BASE});
    end
    repeat (2) @(posedge CLK);
    final_report();
  end
endmodule : epmg_top_bench

// file: verification/epmg_top_properties.sv
// Concurrent checks on the ports of the pod mode gating block
`timescale 1ns/100ps
module epmg_top_properties #(
  parameter int BANK_PROTECT_REG_WIDTH = 8
) (
  // Clock, reset and mode inputs
  input wire logic                   CLK, RST_N, MONITOR_MODE, EMU_MAPPED,
  // Option selects and processor side
  input wire logic                   GATED_BUS_CLOCK_SELECT, GATED_RW_SELECT, MODE_PIN_LINK,
  input wire logic                   CPU_BUS_CLOCK, CPU_RW, USER_IRQ_N, EMU_RESET, TRACE_COND_B,
  input wire logic [BANK_PROTECT_REG_WIDTH-1:0] BANK_PROTECT_REG_OVERRIDE, BANK_PROTECT_REG,
  // Design outputs
  input wire logic                   TARGET_BUS_CLOCK, TARGET_RW, MODE_PIN_A_OE, NONMASKABLE_IRQ_INPUT,
  input wire logic                   BANK_PROTECT_LOAD, MODE_STATUS_OUT, TRACE_AB_FLAG,
  input wire logic                   TRACE_AB_ONESHOT_FLAG, MONITOR_INDICATOR, EMULATION_INDICATOR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Gates, indicators, trace flags, bank protection reload and pin isolation
  AST_NMI_GATE: assert property (NONMASKABLE_IRQ_INPUT == (USER_IRQ_N | MODE_STATUS_OUT))
    else $error("interrupt gate wrong");
  AST_CLK_GATED: assert property (GATED_BUS_CLOCK_SELECT && (MODE_STATUS_OUT || EMU_MAPPED) |-> !TARGET_BUS_CLOCK)
    else $error("gated bus clock not held low");
  AST_CLK_OPEN: assert property (!GATED_BUS_CLOCK_SELECT |-> TARGET_BUS_CLOCK == CPU_BUS_CLOCK)
    else $error("ungated bus clock differs");
  AST_RW_GATED: assert property (GATED_RW_SELECT && (MODE_STATUS_OUT || EMU_MAPPED) |-> TARGET_RW)
    else $error("gated read write not held high");
  AST_RW_OPEN: assert property (!GATED_RW_SELECT |-> TARGET_RW == CPU_RW)
    else $error("ungated read write differs");
  AST_MODE_FOLLOW: assert property ($changed(MODE_STATUS_OUT) |-> MODE_STATUS_OUT == MONITOR_MODE)
    else $error("mode status moved against mode input");
  AST_INDICATORS: assert property (MONITOR_INDICATOR == MODE_STATUS_OUT && EMULATION_INDICATOR != MONITOR_INDICATOR)
    else $error("indicators disagree with mode");
  AST_B_WINS: assert property (TRACE_COND_B [*5] |-> TRACE_AB_FLAG)
    else $error("trace flag low while B held");
  AST_ONESHOT: assert property (TRACE_AB_FLAG |-> TRACE_AB_ONESHOT_FLAG)
    else $error("oneshot flag low while trace flag high");
  AST_RELOAD: assert property ($rose(EMU_RESET) |-> ##[1:4] BANK_PROTECT_LOAD)
    else $error("no bank protect reload");
  AST_RELOAD_VAL: assert property (BANK_PROTECT_LOAD |-> BANK_PROTECT_REG == BANK_PROTECT_REG_OVERRIDE ##1 !BANK_PROTECT_LOAD)
    else $error("bank protect value or pulse wrong");
  AST_ISOLATE: assert property (MODE_PIN_A_OE == MODE_PIN_LINK)
    else $error("mode pin drive enable wrong");
endmodule : epmg_top_properties
bind epmg_top epmg_top_properties #(.BANK_PROTECT_REG_WIDTH(BANK_PROTECT_REG_WIDTH)) u_props (.*);
